// ### wtw_pkg.sv
package wtw_pkg;

	// ----------------------------------------------------------------
	// Register addresses (frame bits 15:13)
	// ----------------------------------------------------------------
	localparam logic [2:0] WD_CTRL_ADDR = 3'h0;
	localparam logic [2:0] ST_ADDR = 3'h3;

	// ----------------------------------------------------------------
	// Frame and field layout
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 13;
	localparam int LOCK_BIT = 12;
	localparam int MAIN_LOW_BIT = 11;
	localparam int XCVR_LOW_BIT = 10;
	localparam int LIN_A_BIT = 9;
	localparam int LIN_B_BIT = 8;
	localparam int CYCLIC_BIT = 7;
	localparam int WAKE_A_BIT = 6;
	localparam int POWER_UP_BIT = 5;
	localparam int WAKE_B_BIT = 4;
	localparam int CAN_WAKE_BIT = 3;
	localparam int MSEL_BIT = 11;
	localparam int PER_HI = 10;
	localparam int PER_LO = 8;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [15:0] FLAG_MASK = 16'h0FF8;
	localparam logic [15:0] ST_RST = 16'h0020;
	localparam logic [2:0] PER_DEF = 3'h4;
	localparam logic MSEL_RST = 1'b0;

	// ----------------------------------------------------------------
	// Timing: one oscillator tick per millisecond
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;

	// Watchdog operating mode, one-hot
	typedef enum logic [2:0] {
		WTW_OFF = 3'b001,
		WTW_WINDOW = 3'b010,
		WTW_TIMEOUT = 3'b100
	} wtw_mode_t;

	// Period code to length in ticks (ms)
	function automatic logic [12:0] wtw_period_ms(input logic [2:0] code);
		logic [12:0] ms;
		ms = 13'h0080;
		unique case (code)
			3'h0: ms = 13'h0008;
			3'h1: ms = 13'h0010;
			3'h2: ms = 13'h0020;
			3'h3: ms = 13'h0040;
			3'h4: ms = 13'h0080;
			3'h5: ms = 13'h0100;
			3'h6: ms = 13'h0400;
			3'h7: ms = 13'h1000;
		endcase
		return ms;
	endfunction : wtw_period_ms

endpackage : wtw_pkg

// ### wtw_reg_if.sv
`timescale 1ns/100ps
// Register access between the serial front end and the core
interface wtw_reg_if;
	logic [2:0] addr; // Register selected by the frame
	logic [15:0] rdata; // Read word of that register
	logic [15:0] wdata; // Whole received frame
	logic wr_stb; // One-cycle pulse at frame end

	modport spi (output addr, output wdata, output wr_stb, input rdata);
	modport core (input addr, input wdata, input wr_stb, output rdata);
endinterface : wtw_reg_if

// ### wtw_spi_slave.sv
`timescale 1ns/100ps
// Serial slave: 16-bit frames, MSB first, sampled on rising SCK
module wtw_spi_slave
	import wtw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	input wire logic spi_csn_n,
	output logic spi_miso,
	wtw_reg_if.spi bus
);

	// ----------------------------------------------------------------
	// Pin synchronisers {csn, sck, mosi}
	// ----------------------------------------------------------------
	logic [2:0] s1_r, s2_r, s3_r; // Three-stage chain
	logic [2:0] lvl_r, lvl_nxt; // Accepted levels
	logic [4:0] cnt_r; // Bits received in frame
	logic [15:0] sh_r; // Receive shift register
	logic [2:0] addr_r; // Latched address

	// Idle is chip select high
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s1_r <= 3'h4;
			s2_r <= 3'h4;
			s3_r <= 3'h4;
			lvl_r <= 3'h4;
		end
		else
		begin
			s1_r <= {spi_csn_n, spi_sck, spi_mosi};
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	// A level counts only once stages two and three agree
	assign lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);

	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_r <= 5'h00;
			sh_r <= 16'h0000;
			addr_r <= 3'h0;
			spi_miso <= 1'b0;
			bus.wr_stb <= 1'b0;
			bus.wdata <= 16'h0000;
		end
		else
		begin
			bus.wr_stb <= 1'b0;
			if (lvl_r[2] && !lvl_nxt[2])
			begin
				// Frame start
				cnt_r <= 5'h00;
				spi_miso <= 1'b0;
			end
			else if (!lvl_r[2] && lvl_nxt[2])
			begin
				// Frame end; only exact 16-bit frames write
				spi_miso <= 1'b0;
				if (cnt_r == 5'(FRAME_BITS))
				begin
					bus.wr_stb <= 1'b1;
					bus.wdata <= sh_r;
				end
			end
			else if (!lvl_r[2] && !lvl_r[1] && lvl_nxt[1])
			begin
				// Rising SCK: take a bit, saturate the count
				sh_r <= {sh_r[14:0], lvl_nxt[0]};
				if (cnt_r != 5'h1F)
					cnt_r <= cnt_r + 5'h01;
				if (cnt_r == 5'h02)
					addr_r <= {sh_r[1:0], lvl_nxt[0]};
			end
			else if (!lvl_r[2] && lvl_r[1] && !lvl_nxt[1])
			begin
				// Falling SCK: present read bit once address is known
				if (cnt_r >= 5'h03 && cnt_r < 5'(FRAME_BITS))
					spi_miso <= bus.rdata[4'(5'h0F - cnt_r)];
				else
					spi_miso <= 1'b0;
			end
		end
	end

	assign bus.addr = addr_r;

endmodule : wtw_spi_slave

// ### wtw_watchdog.sv
`timescale 1ns/100ps
module wtw_watchdog
	import wtw_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC // Clock cycles per 1 ms tick
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	input wire logic spi_csn_n,
	output logic spi_miso,
	input wire logic wd_disable_pin,
	input wire logic [1:0] system_mode_code,
	input wire logic sys_overtemp,
	input wire logic ev_main_low,
	input wire logic ev_xcvr_low,
	input wire logic ev_lin_a,
	input wire logic ev_lin_b,
	input wire logic ev_wake_a,
	input wire logic ev_wake_b,
	input wire logic ev_can,
	output logic wd_reset_req,
	output wtw_mode_t wd_mode,
	output logic irq_pending
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int DIV_W = $clog2(TICK_CYCLES + 1);
	wtw_reg_if bus (); // Link to serial front end
	logic [15:0] st_r, st_nxt; // Pending flags, bits 11:3 only
	logic lock_r; // Write lock flag
	logic msel_r; // Watchdog mode select
	logic [2:0] per_r; // Period select code
	logic [12:0] cnt_r; // Ticks since period start
	logic [DIV_W-1:0] div_r; // Tick divider
	logic tick_r; // 1 ms enable pulse
	logic [2:0] pin_s_r; // Disable pin synchroniser
	logic pin_lvl_r; // Accepted pin level
	logic pin_prime_r; // First agreement seen
	wtw_mode_t mode_nxt; // Next watchdog mode
	logic [15:0] set_v, clr_v; // Flag set and clear vectors
	logic wr_st, wr_wd; // Effective register writes
	logic normal, standby, sleep; // Decoded system mode
	logic pending; // Any flag pending
	logic [12:0] per_ms, half_ms; // Trigger times
	logic ovf, early, cyc_set; // Watchdog events
	logic pin_chg, msel_chg, msel_ok; // Reset causes and gate
	logic rst_nxt; // System reset request

	// ----------------------------------------------------------------
	// Serial front end
	// ----------------------------------------------------------------
	wtw_spi_slave i_wtw_spi_slave (
		.mclk(mclk),
		.rst_n(rst_n),
		.spi_sck(spi_sck),
		.spi_mosi(spi_mosi),
		.spi_csn_n(spi_csn_n),
		.spi_miso(spi_miso),
		.bus(bus)
	);

	// ----------------------------------------------------------------
	// System mode decode
	// ----------------------------------------------------------------
	assign normal = system_mode_code[1];
	assign standby = (system_mode_code == 2'b00);
	assign sleep = (system_mode_code == 2'b01);
	assign pending = |(st_r & FLAG_MASK);

	// ----------------------------------------------------------------
	// Write decode; a frame with the lock bit set is read only
	// ----------------------------------------------------------------
	assign wr_st = bus.wr_stb && bus.addr == ST_ADDR && !bus.wdata[LOCK_BIT];
	assign wr_wd = bus.wr_stb && bus.addr == WD_CTRL_ADDR && !bus.wdata[LOCK_BIT];

	// Mode select may not move in Standby while anything is pending
	assign msel_ok = !(standby && pending);
	assign msel_chg = wr_wd && msel_ok && normal && (bus.wdata[MSEL_BIT] != msel_r);

	// ----------------------------------------------------------------
	// Read data; fixed address and zero reserved bits
	// ----------------------------------------------------------------
	always_comb
	begin
		bus.rdata = 16'h0000;
		if (bus.addr == ST_ADDR)
			bus.rdata = {ST_ADDR, lock_r, st_r[11:3], 3'h0};
		else if (bus.addr == WD_CTRL_ADDR)
			bus.rdata = {WD_CTRL_ADDR, 1'b0, msel_r, per_r, 8'h00};
	end

	// ----------------------------------------------------------------
	// Lock flag: last status frame's lock bit
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			lock_r <= 1'b0;
		else if (bus.wr_stb && bus.addr == ST_ADDR)
			lock_r <= bus.wdata[LOCK_BIT];
	end

	// ----------------------------------------------------------------
	// Interrupt flags; a set in the clear cycle wins
	// ----------------------------------------------------------------
	always_comb
	begin
		set_v = 16'h0000;
		set_v[MAIN_LOW_BIT] = ev_main_low;
		set_v[XCVR_LOW_BIT] = ev_xcvr_low;
		set_v[LIN_A_BIT] = ev_lin_a;
		set_v[LIN_B_BIT] = ev_lin_b;
		set_v[CYCLIC_BIT] = cyc_set;
		set_v[WAKE_A_BIT] = ev_wake_a;
		set_v[WAKE_B_BIT] = ev_wake_b;
		set_v[CAN_WAKE_BIT] = ev_can;
		clr_v = wr_st ? (bus.wdata & FLAG_MASK) : 16'h0000;
		st_nxt = ((st_r & ~clr_v) | set_v) & FLAG_MASK;
	end

	// Power-up flag comes up set
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			msel_r <= MSEL_RST;
		else if (wr_wd && msel_ok)
			msel_r <= bus.wdata[MSEL_BIT];
	end

	// Period falls back to default on any watchdog reset
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			per_r <= PER_DEF;
		else if (rst_nxt)
			per_r <= PER_DEF;
		else if (wr_wd)
			per_r <= bus.wdata[PER_HI:PER_LO];
	end

	// ----------------------------------------------------------------
	// Disable pin: three flops, change counts when two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pin_s_r <= 3'h0;
			pin_lvl_r <= 1'b0;
			pin_prime_r <= 1'b0;
		end
		else
		begin
			pin_s_r <= {pin_s_r[1:0], wd_disable_pin};
			if (pin_s_r[1] == pin_s_r[2])
			begin
				// First agreement only loads; avoids a false reset at power-up
				pin_lvl_r <= pin_s_r[2];
				pin_prime_r <= 1'b1;
			end
		end
	end

	assign pin_chg = pin_prime_r && (pin_s_r[1] == pin_s_r[2]) && (pin_s_r[2] != pin_lvl_r);

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_nxt = WTW_OFF;
		if (pin_lvl_r || sys_overtemp || sleep)
			mode_nxt = WTW_OFF;
		else if (normal && !msel_r)
			mode_nxt = WTW_WINDOW;
		else if (normal && msel_r)
			mode_nxt = WTW_TIMEOUT;
		else if (standby && (!msel_r || pending))
			mode_nxt = WTW_TIMEOUT;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			wd_mode <= WTW_OFF;
		else
			wd_mode <= mode_nxt;
	end

	// ----------------------------------------------------------------
	// Oscillator tick divider; runs free like the real oscillator
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			div_r <= '0;
			tick_r <= 1'b0;
		end
		else if (div_r == DIV_W'(TICK_CYCLES - 1))
		begin
			div_r <= '0;
			tick_r <= 1'b1;
		end
		else
		begin
			div_r <= div_r + DIV_W'(1);
			tick_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog events
	// ----------------------------------------------------------------
	assign per_ms = wtw_period_ms(per_r);
	assign half_ms = per_ms >> 1;
	// Any period change clears the count, so a shorter period runs in full from zero
	assign ovf = (wd_mode != WTW_OFF) && tick_r && (cnt_r >= per_ms - 13'h0001);
	assign early = (wd_mode == WTW_WINDOW) && wr_wd && (cnt_r < half_ms);
	assign cyc_set = (wd_mode == WTW_TIMEOUT) && ovf && !st_r[CYCLIC_BIT];

	always_comb
	begin
		rst_nxt = 1'b0;
		unique case (wd_mode)
			WTW_WINDOW: rst_nxt = early || ovf;
			WTW_TIMEOUT: rst_nxt = ovf && st_r[CYCLIC_BIT];
			WTW_OFF: rst_nxt = 1'b0;
			default: rst_nxt = 1'b0;
		endcase
		if (pin_chg && (normal || standby))
			rst_nxt = 1'b1;
		if (msel_chg)
			rst_nxt = 1'b1;
	end

	// Reset request: one-cycle pulse to the reset block
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			wd_reset_req <= 1'b0;
		else
			wd_reset_req <= rst_nxt;
	end

	// ----------------------------------------------------------------
	// Period counter
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cnt_r <= 13'h0000;
		else if (mode_nxt == WTW_OFF || wd_mode == WTW_OFF)
			cnt_r <= 13'h0000;
		else if (wr_wd || ovf || rst_nxt)
			cnt_r <= 13'h0000;
		else if (tick_r)
			cnt_r <= cnt_r + 13'h0001;
	end

	// Pending summary output
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_pending <= 1'b1;
		else
			irq_pending <= |st_nxt;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_lock_blocks;
		@(posedge mclk) disable iff (!rst_n)
		(bus.wr_stb && bus.addr == ST_ADDR && bus.wdata[LOCK_BIT] && !ev_can
			&& st_r[CAN_WAKE_BIT]) |=> st_r[CAN_WAKE_BIT];
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("locked write cleared a flag");

	property p_clear_one;
		@(posedge mclk) disable iff (!rst_n)
		(wr_st && bus.wdata[CAN_WAKE_BIT] && !ev_can) |=> !st_r[CAN_WAKE_BIT];
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("write one did not clear");

	property p_set_wins;
		@(posedge mclk) disable iff (!rst_n)
		(ev_main_low |=> st_r[MAIN_LOW_BIT]) and (ev_lin_a |=> st_r[LIN_A_BIT]);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost");

	property p_early;
		@(posedge mclk) disable iff (!rst_n)
		early |=> wd_reset_req ##1 (per_r == PER_DEF);
	endproperty
	a_early: assert property (p_early) else $error("early trigger gave no reset");

	property p_win_ovf;
		@(posedge mclk) disable iff (!rst_n)
		(wd_mode == WTW_WINDOW && ovf) |=> (wd_reset_req && cnt_r == 13'h0000);
	endproperty
	a_win_ovf: assert property (p_win_ovf) else $error("window overflow gave no reset");

	property p_open_trig;
		@(posedge mclk) disable iff (!rst_n)
		(wd_mode == WTW_WINDOW && wr_wd && cnt_r >= half_ms && !msel_chg && !pin_chg)
			|=> (!wd_reset_req && cnt_r == 13'h0000);
	endproperty
	a_open_trig: assert property (p_open_trig) else $error("open trigger mishandled");

	property p_to_first;
		@(posedge mclk) disable iff (!rst_n)
		(cyc_set && !pin_chg && !msel_chg) |=> (st_r[CYCLIC_BIT] && !wd_reset_req);
	endproperty
	a_to_first: assert property (p_to_first) else $error("cyclic not set");

	property p_to_second;
		@(posedge mclk) disable iff (!rst_n)
		(wd_mode == WTW_TIMEOUT && ovf && st_r[CYCLIC_BIT]) |=> wd_reset_req;
	endproperty
	a_to_second: assert property (p_to_second) else $error("second overflow no reset");

	property p_pin_off;
		@(posedge mclk) disable iff (!rst_n)
		pin_lvl_r |=> (wd_mode == WTW_OFF);
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("watchdog on with pin high");

	property p_msel_frozen;
		@(posedge mclk) disable iff (!rst_n)
		(wr_wd && standby && pending) |=> $stable(msel_r);
	endproperty
	a_msel_frozen: assert property (p_msel_frozen) else $error("mode select changed");

	property p_reset_period;
		@(posedge mclk) disable iff (!rst_n)
		wd_reset_req |-> (per_r == PER_DEF);
	endproperty
	a_reset_period: assert property (p_reset_period) else $error("period not default");

endmodule : wtw_watchdog

// ### wtw_mcu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Microcontroller side: serial master, mode 0
// ----------------------------------------
module wtw_mcu_model
(
	input wire logic mclk,
	output logic spi_sck,
	output logic spi_mosi,
	output logic spi_csn_n,
	input wire logic spi_miso
);
	localparam int HALF = 6; // Clock cycles per SCK phase, kept above the 4-cycle floor

	// Idle bus: clock stands still low, select released
	initial
	begin
		spi_sck = 1'b0;
		spi_mosi = 1'b1;
		spi_csn_n = 1'b1;
	end

	// Whole 16-bit frame, MSB first; read bits captured just before each rise
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge mclk);
		spi_csn_n = 1'b0;
		for (int k = 15; k >= 0; k--)
		begin
			spi_mosi = tx[k];
			repeat (HALF) @(negedge mclk);
			// First three read bits are not yet known to the slave
			if (k <= 12)
				rx[k] = spi_miso;
			spi_sck = 1'b1;
			repeat (HALF) @(negedge mclk);
			spi_sck = 1'b0;
		end
		repeat (HALF) @(negedge mclk);
		spi_csn_n = 1'b1;
		// Data line no longer meaningful: show the inverse of the last bit
		spi_mosi = ~tx[0];
		// Margin for the synchronised select and the internal write
		repeat (HALF + 8) @(negedge mclk);
	endtask : xfer
endmodule : wtw_mcu_model

// ### wtw_watchdog_tb.sv
`timescale 1ns/100ps
module wtw_watchdog_tb import wtw_pkg::*;;
	// ----------------------------------------
	// Compare and count
	// ----------------------------------------
	`define CHK(nm, e, g) \
	begin \
		checks++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("MISMATCH %s exp %h got %h", nm, e, g); \
		end \
	end

	localparam int TICKS = 10; // Short tick so one 128-tick period is 1280 cycles
	localparam int POS [7] = '{MAIN_LOW_BIT, XCVR_LOW_BIT, LIN_A_BIT, LIN_B_BIT,
		WAKE_A_BIT, WAKE_B_BIT, CAN_WAKE_BIT}; // Flag bit of each event input

	logic mclk = 1'b0; // System clock
	logic rst_n; // Synchronous reset
	logic spi_sck, spi_mosi, spi_csn_n, spi_miso; // Serial pins
	logic wd_disable_pin; // Watchdog disable pin
	logic [1:0] system_mode_code; // System mode
	logic sys_overtemp; // Overtemp mode
	logic [6:0] ev; // Event pulses, order as POS
	logic wd_reset_req; // Reset request pulse
	wtw_mode_t wd_mode; // Watchdog mode
	logic irq_pending; // Any flag pending
	logic [15:0] rd; // Last read word
	logic [12:0] e; // Expected read bits
	int err_total = 0; // Mismatches
	int checks = 0; // Comparisons
	int rst_seen = 0; // Reset request pulses seen
	int mark; // Pulse count at start of a span

	always #4 mclk = ~mclk;

	// Count reset requests; a pulse stands for one cycle
	always @(posedge mclk)
		if (wd_reset_req === 1'b1)
			rst_seen++;

	wtw_watchdog #(.TICK_CYCLES(TICKS)) i_wtw_watchdog (.mclk(mclk), .rst_n(rst_n),
		.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_csn_n(spi_csn_n),
		.spi_miso(spi_miso), .wd_disable_pin(wd_disable_pin),
		.system_mode_code(system_mode_code), .sys_overtemp(sys_overtemp),
		.ev_main_low(ev[0]), .ev_xcvr_low(ev[1]), .ev_lin_a(ev[2]), .ev_lin_b(ev[3]),
		.ev_wake_a(ev[4]), .ev_wake_b(ev[5]), .ev_can(ev[6]),
		.wd_reset_req(wd_reset_req), .wd_mode(wd_mode), .irq_pending(irq_pending));

	wtw_mcu_model i_wtw_mcu_model (.mclk(mclk), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
		.spi_csn_n(spi_csn_n), .spi_miso(spi_miso));

	// ----------------------------------------
	// Frame helpers
	// ----------------------------------------
	function automatic logic [15:0] frm(input logic [2:0] a, input logic lk,
		input logic [11:0] d);
		return {a, lk, d};
	endfunction : frm

	// Status read: writable frame with no clear bits, so nothing changes but lock
	task automatic rd_st;
		i_wtw_mcu_model.xfer(frm(ST_ADDR, 1'b0, 12'h000), rd);
	endtask : rd_st

	// Control read: read-only frame, so no trigger
	task automatic rd_ctl;
		i_wtw_mcu_model.xfer(frm(WD_CTRL_ADDR, 1'b1, 12'h000), rd);
	endtask : rd_ctl

	task automatic wr(input logic [2:0] a, input logic [11:0] d);
		i_wtw_mcu_model.xfer(frm(a, 1'b0, d), rd);
	endtask : wr

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd_st;
		`CHK("status reset", 13'h0020, rd[12:0])
		rd_ctl;
		`CHK("control reset", 12'h400, rd[11:0])
		`CHK("mode sleep", WTW_OFF, wd_mode)
		`CHK("pending reset", 1'b1, irq_pending)
	endtask : t_reset

	// Each event sets its flag; a one clears it; reserved bits stay zero
	task automatic t_flags;
		for (int i = 0; i < 7; i++)
		begin
			ev[i] = 1'b1;
			@(negedge mclk);
			ev = 7'h00;
			e = 13'h0020 | (13'h0001 << POS[i]);
			rd_st;
			`CHK("flag set", e, rd[12:0])
			wr(ST_ADDR, 12'h007 | (12'h001 << POS[i]));
			rd_st;
			`CHK("flag cleared", 13'h0020, rd[12:0])
		end
		wr(ST_ADDR, 12'h020);
		rd_st;
		`CHK("power flag cleared", 13'h0000, rd[12:0])
		`CHK("none pending", 1'b0, irq_pending)
	endtask : t_flags

	// Read-only frame locks the register and its clear bits do nothing
	task automatic t_lock;
		ev[6] = 1'b1;
		@(negedge mclk);
		ev = 7'h00;
		i_wtw_mcu_model.xfer(frm(ST_ADDR, 1'b1, 12'h008), rd);
		i_wtw_mcu_model.xfer(frm(ST_ADDR, 1'b1, 12'h008), rd);
		`CHK("locked read", 13'h1008, rd[12:0])
		wr(ST_ADDR, 12'h008);
		rd_st;
		`CHK("unlocked clear", 13'h0000, rd[12:0])
	endtask : t_lock

	// Window: early trigger, open-half trigger, then overflow
	task automatic t_window;
		wr(WD_CTRL_ADDR, 12'h500);
		rd_ctl;
		`CHK("period select", 12'h500, rd[11:0])
		system_mode_code = 2'b10;
		repeat (3) @(negedge mclk);
		`CHK("mode window", WTW_WINDOW, wd_mode)
		mark = rst_seen;
		wr(WD_CTRL_ADDR, 12'h500);
		`CHK("early trigger", 1, rst_seen - mark)
		rd_ctl;
		`CHK("period default", 12'h400, rd[11:0])
		repeat (480) @(negedge mclk);
		mark = rst_seen;
		wr(WD_CTRL_ADDR, 12'h400);
		`CHK("open trigger", 0, rst_seen - mark)
		repeat (1200) @(negedge mclk);
		`CHK("no early overflow", 0, rst_seen - mark)
		repeat (150) @(negedge mclk);
		`CHK("window overflow", 1, rst_seen - mark)
	endtask : t_window

	// Timeout: first overflow sets cyclic, second resets; select change resets
	task automatic t_timeout;
		system_mode_code = 2'b01;
		wr(WD_CTRL_ADDR, 12'hC00);
		mark = rst_seen;
		system_mode_code = 2'b10;
		repeat (3) @(negedge mclk);
		`CHK("mode timeout", WTW_TIMEOUT, wd_mode)
		repeat (1350) @(negedge mclk);
		rd_st;
		`CHK("cyclic set", 13'h0080, rd[12:0])
		`CHK("no reset yet", 0, rst_seen - mark)
		repeat (900) @(negedge mclk);
		`CHK("still no reset", 0, rst_seen - mark)
		repeat (200) @(negedge mclk);
		`CHK("pending overflow", 1, rst_seen - mark)
		mark = rst_seen;
		wr(WD_CTRL_ADDR, 12'h000);
		`CHK("select change", 1, rst_seen - mark)
		mark = rst_seen;
		wd_disable_pin = 1'b1;
		repeat (10) @(negedge mclk);
		`CHK("mode pin off", WTW_OFF, wd_mode)
		wd_disable_pin = 1'b0;
		repeat (10) @(negedge mclk);
		`CHK("pin changes", 2, rst_seen - mark)
	endtask : t_timeout

	// Standby: select frozen while pending, off when clear, back on when pending
	task automatic t_standby;
		system_mode_code = 2'b00;
		repeat (3) @(negedge mclk);
		`CHK("standby timeout", WTW_TIMEOUT, wd_mode)
		// Keep the default period so no overflow lands inside the readback
		wr(WD_CTRL_ADDR, 12'hC00);
		rd_ctl;
		`CHK("select frozen", 12'h400, rd[11:0])
		wr(ST_ADDR, 12'h080);
		wr(WD_CTRL_ADDR, 12'h800);
		`CHK("standby off", WTW_OFF, wd_mode)
		ev[4] = 1'b1;
		@(negedge mclk);
		ev = 7'h00;
		repeat (3) @(negedge mclk);
		`CHK("pending reenable", WTW_TIMEOUT, wd_mode)
		sys_overtemp = 1'b1;
		repeat (3) @(negedge mclk);
		`CHK("overtemp off", WTW_OFF, wd_mode)
	endtask : t_standby

	// ----------------------------------------
	// Verdict, watchdog and main sequence
	// ----------------------------------------
	task automatic give_verdict;
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	// Run needs about 13000 cycles; allow well over that
	initial
	begin
		repeat (40000) @(posedge mclk);
		err_total++;
		give_verdict;
	end

	initial
	begin
		rst_n = 1'b0;
		wd_disable_pin = 1'b0;
		system_mode_code = 2'b01;
		sys_overtemp = 1'b0;
		ev = 7'h00;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		t_reset;
		t_flags;
		t_lock;
		t_window;
		t_timeout;
		t_standby;
		give_verdict;
	end
endmodule : wtw_watchdog_tb
